//--- design/ost_defines.vh
`ifndef OST_DEFINES_VH
`define OST_DEFINES_VH

// Register byte offsets
`define OST_CFG_OFS      6'h00
`define OST_CMD_OFS      6'h04
`define OST_LIMIT_OFS    6'h08
`define OST_INTTRIP_OFS  6'h0C
`define OST_EXTTRIP_OFS  6'h10
`define OST_MAXGOV_OFS   6'h14
`define OST_DWELL1_OFS   6'h18
`define OST_DWELL2_OFS   6'h1C
`define OST_PEAK_OFS     6'h20
`define OST_STATUS_OFS   6'h24
`define OST_ISTAT_OFS    6'h28
`define OST_ICLR_OFS     6'h2C
`define OST_IEN_OFS      6'h30

// CFG fields
`define OST_CFG_EXT      0
`define OST_CFG_TRIPLIM  1
`define OST_CFG_GENAPP   2
`define OST_CFG_RST      3'h2

// CMD fields (write-only pulses)
`define OST_CMD_TOOL_GO  0
`define OST_CMD_SER_GO   1
`define OST_CMD_STOP     2
`define OST_CMD_TOOL_CLR 3
`define OST_CMD_SER_CLR  4

// Event bits in interrupt status
`define OST_EV_START     0
`define OST_EV_REFUSE    1
`define OST_EV_ALARM     2
`define OST_EV_ESD       3
`define OST_EV_RAMPBK    4
`define OST_EV_W         5

// Reset values of settings (speed units, ms)
`define OST_LIMIT_RST    16'h1400
`define OST_INTTRIP_RST  16'h1300
`define OST_EXTTRIP_RST  16'h1380
`define OST_MAXGOV_RST   16'h1200
`define OST_DWELL_MS     16'hEA60

// Timing
`define OST_CLK_NS       40
`define OST_TICK_NS      1000000
`define OST_TICK_CYC     (`OST_TICK_NS / `OST_CLK_NS)
`define OST_BLINK_MS     16'h01F4

// Command sources
`define OST_SRC_TOOL     2'h0
`define OST_SRC_SER      2'h1
`define OST_SRC_CONT     2'h2

// AXI responses
`define OST_RESP_OK      2'h0
`define OST_RESP_ERR     2'h2

`endif

//--- design/ost_supervisor.v
`include "ost_defines.vh"

module ost_supervisor #(
  parameter SPD_W    = 16,
  parameter TICK_CYC = `OST_TICK_CYC
) (
  input  wire             ref_clk,        // 25 MHz clock
  input  wire             rst_n,          // Async reset, active low
  input  wire [5:0]       s_axi_awaddr,   // Write address
  input  wire             s_axi_awvalid,  // Write address valid
  output reg              s_axi_awready,  // Write address ready
  input  wire [31:0]      s_axi_wdata,    // Write data
  input  wire [3:0]       s_axi_wstrb,    // Byte strobes
  input  wire             s_axi_wvalid,   // Write data valid
  output reg              s_axi_wready,   // Write data ready
  output reg  [1:0]       s_axi_bresp,    // Write response
  output reg              s_axi_bvalid,   // Write response valid
  input  wire             s_axi_bready,   // Write response ready
  input  wire [5:0]       s_axi_araddr,   // Read address
  input  wire             s_axi_arvalid,  // Read address valid
  output reg              s_axi_arready,  // Read address ready
  output reg  [31:0]      s_axi_rdata,    // Read data
  output reg  [1:0]       s_axi_rresp,    // Read response
  output reg              s_axi_rvalid,   // Read data valid
  input  wire             s_axi_rready,   // Read data ready
  input  wire [SPD_W-1:0] speed,          // Sensed turbine speed
  input  wire [SPD_W-1:0] sp_request,     // Setpoint from setpoint logic
  input  wire             sp_adjust,      // Setpoint raise/lower pulse
  input  wire             sp_at_max,      // Setpoint at max governor
  input  wire             speed_in_ctrl,  // Speed PID in control
  input  wire             aux_en,         // Auxiliary enabled
  input  wire             casc_en,        // Cascade enabled
  input  wire             extr_en,        // Ext/adm enabled
  input  wire             rmt_sp_en,      // Remote setpoint enabled
  input  wire             gen_bkr_closed, // Generator breaker closed
  input  wire             test_contact,   // Test contact input, closed high
  output reg  [SPD_W-1:0] sp_cmd,         // Capped setpoint
  output reg              ramp_back,      // Ramp setpoint to max governor
  output reg              esd,            // Emergency shutdown
  output reg              alarm,          // Overspeed alarm
  output reg              trip_relay,     // Overspeed trip indication
  output reg              test_relay,     // Test active indication
  output reg              irq             // Interrupt, active high
);

  localparam ST_IDLE = 2'h0;
  localparam ST_TEST = 2'h1;
  localparam ST_SHUT = 2'h2;

  reg [2:0]       cfg;
  reg [SPD_W-1:0] lim;
  reg [SPD_W-1:0] int_trip;
  reg [SPD_W-1:0] ext_trip;
  reg [SPD_W-1:0] max_gov;
  reg [15:0]      dwell1_ms;
  reg [15:0]      dwell2_ms;
  reg [SPD_W-1:0] peak;
  reg [`OST_EV_W-1:0] ev_stat;
  reg [`OST_EV_W-1:0] ev_en;
  reg [1:0]       state;
  reg [1:0]       src;
  reg             cont_d;
  reg [31:0]      tick_cnt;
  reg             tick;
  reg [15:0]      dw1_cnt;
  reg [15:0]      dw2_cnt;
  reg [15:0]      blink_cnt;
  reg             blink;
  reg             aw_hold;
  reg             w_hold;
  reg [5:0]       aw_addr;
  reg [31:0]      w_data;
  reg [3:0]       w_strb;

  // Write address and data latched separately, either order
  wire wr_go = aw_hold && w_hold && !s_axi_bvalid;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [SPD_W-1:0] spd_msk = wmask[SPD_W-1:0];
  wire [15:0]      ms_msk  = wmask[15:0];

  wire cmd_wr = wr_go && (aw_addr == `OST_CMD_OFS) && w_strb[0];
  wire tool_go = cmd_wr && w_data[`OST_CMD_TOOL_GO];
  wire ser_go  = cmd_wr && w_data[`OST_CMD_SER_GO];
  wire stop_go = cmd_wr && w_data[`OST_CMD_STOP];
  wire clr_pk  = cmd_wr && (w_data[`OST_CMD_TOOL_CLR] || w_data[`OST_CMD_SER_CLR]);
  wire cont_rise = test_contact && !cont_d;
  wire cont_fall = !test_contact && cont_d;
  wire any_go = tool_go || ser_go || cont_rise;
  wire permit = speed_in_ctrl && !aux_en && !casc_en && !extr_en && !rmt_sp_en &&
                !(cfg[`OST_CFG_GENAPP] && gen_bkr_closed) && sp_at_max;

  wire ext_type  = cfg[`OST_CFG_EXT];
  wire at_int    = speed >= int_trip;
  wire above_int = speed > int_trip;
  wire at_lim    = speed >= lim;
  wire dw1_done  = (dw1_cnt >= dwell1_ms) && (speed > max_gov);
  wire dw2_done  = (dw2_cnt >= dwell2_ms) && (speed > ext_trip);
  wire in_test   = (state == ST_TEST);

  // Shutdown causes while testing
  wire lim_trip  = at_lim && cfg[`OST_CFG_TRIPLIM];
  wire int_cmd_trip = at_int && !ext_type && (src != `OST_SRC_CONT);
  wire cont_trip = (src == `OST_SRC_CONT) && cont_fall &&
                   (alarm || at_int || ext_type);
  wire test_esd  = in_test && !stop_go && !ser_go && !tool_go &&
                   (lim_trip || int_cmd_trip || cont_trip || dw2_done);
  // Normal protection outside a test
  wire idle_esd  = (state == ST_IDLE) && at_int && !any_go;
  wire do_esd    = test_esd || idle_esd;
  wire refused   = any_go && !permit && (state == ST_IDLE);
  wire started   = any_go && permit && (state == ST_IDLE);
  wire alarm_set = in_test && at_int && !alarm;

  wire [`OST_EV_W-1:0] ev_now = {dw1_done && !ramp_back, do_esd, alarm_set, refused, started};

  // Test sequencing; a later serial or contact start takes over the source, a tool start does not
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      src        <= `OST_SRC_TOOL;
      cont_d     <= 1'b0;
      esd        <= 1'b0;
      alarm      <= 1'b0;
      trip_relay <= 1'b0;
    end else begin
      cont_d <= test_contact;
      case (state)
        ST_IDLE: begin
          if (started) begin
            state <= ST_TEST;
            alarm <= 1'b0;
            if (cont_rise)
              src <= `OST_SRC_CONT;
            else if (ser_go)
              src <= `OST_SRC_SER;
            else
              src <= `OST_SRC_TOOL;
          end else if (idle_esd) begin
            state      <= ST_SHUT;
            esd        <= 1'b1;
            trip_relay <= 1'b1;
          end
        end
        ST_TEST: begin
          if (at_int)
            alarm <= 1'b1;
          if (stop_go) begin
            state <= ST_IDLE;
          end else if (ser_go) begin
            src <= `OST_SRC_SER;
          end else if (cont_rise) begin
            src <= `OST_SRC_CONT;
          end else if (test_esd) begin
            state      <= ST_SHUT;
            esd        <= 1'b1;
            trip_relay <= 1'b1;
          end else if ((src == `OST_SRC_CONT) && cont_fall) begin
            state <= ST_IDLE;
          end
        end
        ST_SHUT: begin
          // Shutdown holds until an explicit stop command
          if (stop_go) begin
            state      <= ST_IDLE;
            esd        <= 1'b0;
            alarm      <= 1'b0;
            trip_relay <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Millisecond tick, dwell timers and relay blink
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt  <= 32'h0;
      tick      <= 1'b0;
      dw1_cnt   <= 16'h0;
      dw2_cnt   <= 16'h0;
      blink_cnt <= 16'h0;
      blink     <= 1'b0;
      ramp_back <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_CYC - 1);
      if (tick_cnt == TICK_CYC - 1)
        tick_cnt <= 32'h0;
      else
        tick_cnt <= tick_cnt + 32'h1;
      if (!in_test || sp_adjust || speed <= max_gov)
        dw1_cnt <= 16'h0;
      else if (tick && dw1_cnt != 16'hFFFF)
        dw1_cnt <= dw1_cnt + 16'h1;
      if (!in_test || sp_adjust || speed <= ext_trip)
        dw2_cnt <= 16'h0;
      else if (tick && dw2_cnt != 16'hFFFF)
        dw2_cnt <= dw2_cnt + 16'h1;
      if (!in_test || sp_adjust || speed <= max_gov)
        ramp_back <= 1'b0;
      else if (dw1_done)
        ramp_back <= 1'b1;
      if (tick) begin
        if (blink_cnt >= `OST_BLINK_MS - 16'h1) begin
          blink_cnt <= 16'h0;
          blink     <= ~blink;
        end else begin
          blink_cnt <= blink_cnt + 16'h1;
        end
      end
    end
  end

  // Outputs toward setpoint logic and relays
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_cmd     <= {SPD_W{1'b0}};
      test_relay <= 1'b0;
      peak       <= {SPD_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      if (in_test && sp_request > lim)
        sp_cmd <= lim;
      else
        sp_cmd <= sp_request;
      test_relay <= in_test && (!above_int || blink);
      // Clear has priority only over stale value, not the new sample
      if (clr_pk)
        peak <= speed;
      else if (speed > peak)
        peak <= speed;
      irq <= |(ev_stat & ev_en);
    end
  end

  // AXI4-Lite write channel
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OST_RESP_OK;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 6'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > `OST_IEN_OFS) ? `OST_RESP_ERR : `OST_RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable settings and interrupt registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg       <= `OST_CFG_RST;
      lim       <= `OST_LIMIT_RST;
      int_trip  <= `OST_INTTRIP_RST;
      ext_trip  <= `OST_EXTTRIP_RST;
      max_gov   <= `OST_MAXGOV_RST;
      dwell1_ms <= `OST_DWELL_MS;
      dwell2_ms <= `OST_DWELL_MS;
      ev_en     <= {`OST_EV_W{1'b0}};
      ev_stat   <= {`OST_EV_W{1'b0}};
    end else begin
      if (wr_go) begin
        case (aw_addr)
          `OST_CFG_OFS:     cfg       <= w_strb[0] ? w_data[2:0] : cfg;
          `OST_LIMIT_OFS:   lim       <= (lim & ~spd_msk) | (w_data[SPD_W-1:0] & spd_msk);
          `OST_INTTRIP_OFS: int_trip  <= (int_trip & ~spd_msk) | (w_data[SPD_W-1:0] & spd_msk);
          `OST_EXTTRIP_OFS: ext_trip  <= (ext_trip & ~spd_msk) | (w_data[SPD_W-1:0] & spd_msk);
          `OST_MAXGOV_OFS:  max_gov   <= (max_gov & ~spd_msk) | (w_data[SPD_W-1:0] & spd_msk);
          `OST_DWELL1_OFS:  dwell1_ms <= (dwell1_ms & ~ms_msk) | (w_data[15:0] & ms_msk);
          `OST_DWELL2_OFS:  dwell2_ms <= (dwell2_ms & ~ms_msk) | (w_data[15:0] & ms_msk);
          `OST_IEN_OFS:     ev_en     <= w_strb[0] ? w_data[`OST_EV_W-1:0] : ev_en;
          default: ;
        endcase
      end
      // New events win over a clear in the same cycle
      if (wr_go && aw_addr == `OST_ICLR_OFS && w_strb[0])
        ev_stat <= (ev_stat & ~w_data[`OST_EV_W-1:0]) | ev_now;
      else
        ev_stat <= ev_stat | ev_now;
    end
  end

  reg [31:0] rd_mux;
  wire [5:0] rd_ofs = {s_axi_araddr[5:2], 2'h0};
  always @* begin
    case (rd_ofs)
      `OST_CFG_OFS:     rd_mux = {29'h0, cfg};
      `OST_LIMIT_OFS:   rd_mux = {16'h0, lim};
      `OST_INTTRIP_OFS: rd_mux = {16'h0, int_trip};
      `OST_EXTTRIP_OFS: rd_mux = {16'h0, ext_trip};
      `OST_MAXGOV_OFS:  rd_mux = {16'h0, max_gov};
      `OST_DWELL1_OFS:  rd_mux = {16'h0, dwell1_ms};
      `OST_DWELL2_OFS:  rd_mux = {16'h0, dwell2_ms};
      `OST_PEAK_OFS:    rd_mux = {16'h0, peak};
      `OST_STATUS_OFS:  rd_mux = {22'h0, permit, ramp_back, test_relay, trip_relay,
                                  alarm, esd, src, state};
      `OST_ISTAT_OFS:   rd_mux = {27'h0, ev_stat};
      `OST_IEN_OFS:     rd_mux = {27'h0, ev_en};
      default:          rd_mux = 32'h0;
    endcase
  end

  // AXI4-Lite read channel
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `OST_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        if (rd_ofs > `OST_IEN_OFS || rd_ofs == `OST_CMD_OFS || rd_ofs == `OST_ICLR_OFS)
          s_axi_rresp <= `OST_RESP_ERR;
        else
          s_axi_rresp <= `OST_RESP_OK;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- verif/ost_supervisor_monitor.sv
module ost_supervisor_monitor (
  input wire        ref_clk,      // Control clock
  input wire        rst_n,        // Reset, active low
  input wire [15:0] speed,        // Sensed speed
  input wire [15:0] sp_request,   // Requested setpoint
  input wire        sp_adjust,    // Setpoint adjust
  input wire [15:0] sp_cmd,       // Capped setpoint
  input wire        esd,          // Shutdown
  input wire        trip_relay,   // Trip indication
  input wire        alarm,        // Alarm
  input wire        ramp_back,    // Ramp request
  input wire        s_axi_bvalid  // Write response valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // Settings are only valid while the bench leaves them at reset values
  localparam logic [15:0] limit_rst   = 16'h1400;
  localparam logic [15:0] inttrip_rst = 16'h1300;
  localparam logic [15:0] maxgov_rst  = 16'h1200;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sp_cap_a: assert property ($past(rst_n) |-> sp_cmd <= $past(sp_request))
    else $error("setpoint output above request");
  sp_pass_a: assert property ($past(rst_n, 2) && $past(sp_request) <= limit_rst
    |-> sp_cmd == $past(sp_request)) else $error("setpoint below limit not passed");
  trip_esd_a: assert property (trip_relay |-> esd)
    else $error("trip indication without shutdown");
  limit_trip_a: assert property ($past(rst_n) && speed >= limit_rst |-> ##[1:2] esd)
    else $error("no shutdown at test limit");
  esd_stop_a: assert property ($fell(esd) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("shutdown released without a command");
  ramp_cause_a: assert property ($rose(ramp_back) |-> $past(speed) > maxgov_rst)
    else $error("ramp back while below max governor");
  ramp_adj_a: assert property ($rose(ramp_back) |-> !$past(sp_adjust))
    else $error("ramp back right after setpoint move");
  alarm_cause_a: assert property ($rose(alarm) |-> $past(speed) >= inttrip_rst)
    else $error("alarm below internal trip");
endmodule

bind ost_supervisor ost_supervisor_monitor mon (.ref_clk, .rst_n, .speed, .sp_request,
  .sp_adjust, .sp_cmd, .esd, .trip_relay, .alarm, .ramp_back, .s_axi_bvalid);

//--- verif/ost_plant.sv
module ost_plant (
  input  wire        ref_clk,      // Control clock
  input  wire        rst_n,        // Reset, active low
  input  wire [15:0] tgt_speed,    // Speed the turbine heads for
  input  wire [15:0] tgt_sp,       // Setpoint the operator dials in
  input  wire        hold,         // Operator holds the test contact
  output reg  [15:0] speed,        // Sensed speed
  output reg  [15:0] sp_request,   // Setpoint to the supervisor
  output reg         sp_adjust,    // Setpoint moved this cycle
  output reg         test_contact  // Contact, high when closed
);
  timeunit 1ns;
  timeprecision 1ns;
  // Rotor inertia: speed creeps so every threshold is really crossed
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed <= 16'h0000;
      sp_request <= 16'h0000;
      sp_adjust <= 1'h0;
      test_contact <= 1'h0;
    end else begin
      if (speed < tgt_speed) speed <= speed + 16'h0010;
      else if (speed > tgt_speed) speed <= speed - 16'h0010;
      sp_adjust <= (sp_request != tgt_sp);
      sp_request <= tgt_sp;
      test_contact <= hold;
    end
  end
endmodule

//--- verif/test_ost_supervisor.sv
module test_ost_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'h0, rst_n = 1'h0, hold = 1'h0;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] speed, sp_request, sp_cmd, tgt_speed = 16'h1000, tgt_sp = 16'h1200;
  logic        sp_adjust, test_contact, ramp_back, esd, alarm, trip_relay, test_relay, irq;
  logic [6:0]  perm = 7'h03;
  int          num_errors = 0, n_compared = 0;
  localparam int f_alm = 0, f_esd = 1, f_ramp = 2, f_relay = 3, f_spd = 4;
  logic [39:0] rows [12] = '{{6'h00, 2'h0, 32'h2}, {6'h08, 2'h0, 32'h1400},
    {6'h0C, 2'h0, 32'h1300}, {6'h10, 2'h0, 32'h1380}, {6'h14, 2'h0, 32'h1200},
    {6'h18, 2'h0, 32'hEA60}, {6'h1C, 2'h0, 32'hEA60}, {6'h20, 2'h0, 32'h1000},
    {6'h28, 2'h0, 32'h0}, {6'h30, 2'h0, 32'h0}, {6'h34, 2'h2, 32'h0}, {6'h04, 2'h2, 32'h0}};

  always #20 ref_clk = ~ref_clk;

  ost_supervisor #(.TICK_CYC(4)) dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .speed, .sp_request,
    .sp_adjust, .sp_at_max(perm[0]), .speed_in_ctrl(perm[1]), .aux_en(perm[2]),
    .casc_en(perm[3]), .extr_en(perm[4]), .rmt_sp_en(perm[5]), .gen_bkr_closed(perm[6]),
    .test_contact, .sp_cmd, .ramp_back, .esd, .alarm, .trip_relay, .test_relay, .irq);
  ost_plant plant (.ref_clk, .rst_n, .tgt_speed, .tgt_sp, .hold, .speed, .sp_request,
    .sp_adjust, .test_contact);

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [33:0] g, e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic tmo;
    chk(34'h0, 34'h1);
    stop_test;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end while (!s_axi_bvalid && n < 40);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge ref_clk);
    if (n >= 40) tmo;
  endtask
  task automatic rd(input logic [5:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (!s_axi_rvalid && n < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge ref_clk);
    if (n >= 40) tmo;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] m, e);
    rd(a);
    chk(d & m, e);
  endtask
  function automatic logic flag(input int k);
    logic [4:0] f;
    f = {speed == tgt_speed, test_relay, ramp_back, esd, alarm};
    return f[k];
  endfunction
  // Always lets one edge pass, so a target set just before is seen
  task automatic wt(input int k, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (flag(k) !== v && n < lim);
    chk(flag(k), v);
    if (flag(k) !== v) stop_test;
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    wt(f_spd, 1'h1, 400);
    foreach (rows[i]) begin
      rd(rows[i][39:34]);
      chk({r, d}, rows[i][33:0]);
    end
    wr(6'h34, 32'h0);
    chk(r, 2'h2);
    $display("register table done");
    wr(6'h00, 32'h6);
    chk(r, 2'h0);
    wr(6'h30, 32'h1F);
    for (int i = 0; i < 7; i++) begin
      perm <= 7'h03 ^ (7'h01 << i);
      wr(6'h04, 32'h1);
      rchk(6'h24, 32'h3, 32'h0);
      rchk(6'h28, 32'h3, 32'h2);
      chk(irq, 1'h1);
      wr(6'h2C, 32'h1F);
      rchk(6'h28, 32'h1F, 32'h0);
      chk(irq, 1'h0);
    end
    perm <= 7'h03;
    $display("permissive test done");
    wr(6'h30, 32'h0);
    wr(6'h04, 32'h1);
    rchk(6'h24, 32'hF, 32'h1);
    chk(irq, 1'h0);
    tgt_sp <= 16'h1500;
    wr(6'h30, 32'h1);
    rchk(6'h28, 32'h1, 32'h1);
    chk(irq, 1'h1);
    chk(sp_cmd, 16'h1400);
    wt(f_relay, 1'h1, 10);
    tgt_speed <= 16'h1300;
    wt(f_esd, 1'h1, 100);
    chk({alarm, trip_relay}, 2'h3);
    rchk(6'h20, 32'hFFFF, 32'h1300);
    tgt_speed <= 16'h1000;
    tgt_sp <= 16'h1200;
    wt(f_spd, 1'h1, 100);
    wr(6'h04, 32'h4);
    rchk(6'h24, 32'h13, 32'h0);
    chk(trip_relay, 1'h0);
    rchk(6'h20, 32'hFFFF, 32'h1300);
    wr(6'h04, 32'h8);
    rchk(6'h20, 32'hFFFF, 32'h1000);
    wr(6'h2C, 32'h1F);
    $display("tool test done");
    wr(6'h04, 32'h2);
    rchk(6'h24, 32'hF, 32'h5);
    hold <= 1'h1;
    // Contact reaches the block's edge detector two edges later
    repeat (2) @(posedge ref_clk);
    rchk(6'h24, 32'hF, 32'h9);
    wr(6'h04, 32'h2);
    rchk(6'h24, 32'hF, 32'h5);
    wr(6'h04, 32'h4);
    hold <= 1'h0;
    rchk(6'h24, 32'h3, 32'h0);
    $display("source test done");
    wr(6'h00, 32'h7);
    wr(6'h18, 32'h2);
    wr(6'h1C, 32'h3);
    wr(6'h04, 32'h1);
    tgt_speed <= 16'h1350;
    wt(f_alm, 1'h1, 100);
    wt(f_ramp, 1'h1, 40);
    chk(esd, 1'h0);
    tgt_speed <= 16'h1390;
    repeat (10) begin
      tgt_sp <= tgt_sp ^ 16'h0010;
      repeat (4) @(posedge ref_clk);
    end
    chk(esd, 1'h0);
    wt(f_esd, 1'h1, 40);
    chk(trip_relay, 1'h1);
    rchk(6'h20, 32'hFFFF, 32'h1390);
    tgt_speed <= 16'h1000;
    wt(f_spd, 1'h1, 100);
    wr(6'h04, 32'h4);
    wr(6'h04, 32'h10);
    rchk(6'h20, 32'hFFFF, 32'h1000);
    $display("external test done");
    for (int x = 0; x < 2; x++) begin
      wr(6'h00, 32'h6 | x);
      hold <= 1'h1;
      repeat (2) @(posedge ref_clk);
      rchk(6'h24, 32'hF, 32'h9);
      tgt_speed <= 16'h1310;
      wt(f_alm, 1'h1, 100);
      chk(esd, 1'h0);
      wt(f_relay, 1'h0, 2100);
      hold <= 1'h0;
      wt(f_esd, 1'h1, 20);
      tgt_speed <= 16'h1000;
      wt(f_spd, 1'h1, 100);
      wr(6'h04, 32'h4);
    end
    $display("contact test done");
    wr(6'h1C, 32'h100);
    wr(6'h04, 32'h1);
    tgt_speed <= 16'h1400;
    wt(f_spd, 1'h1, 100);
    wt(f_esd, 1'h1, 3);
    rst_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    chk({esd, alarm, trip_relay, test_relay, ramp_back, irq, sp_cmd}, 22'h0);
    tgt_speed <= 16'h1000;
    rst_n <= 1'h1;
    rchk(6'h00, 32'h7, 32'h2);
    $display("reset test done");
    stop_test;
  end
endmodule
